/* File: shared/level_switch_pkg.sv */
`default_nettype none
package level_switch_pkg;
  // Geometry
  localparam int CHANNEL_MAX = 4;
  localparam int LEVEL_W     = 16;
  localparam int BTN_COUNT   = 4;
  localparam int HOLD_W      = 30;
  localparam int IDLE_W      = 37;
  localparam int ITEM_W      = 5;
  localparam int ADR_W       = 8;

  // Timing, figures in their own units
  localparam longint CLK_KHZ         = 250000;
  localparam longint SET_HOLD_MS     = 3000;
  localparam longint SET_HOLD_COUNT  = SET_HOLD_MS * CLK_KHZ;
  localparam longint IDLE_MIN        = 5;
  localparam longint IDLE_COUNT      = IDLE_MIN * 60 * 1000 * CLK_KHZ;

  // Register byte offsets
  localparam logic [ADR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADR_W-1:0] OFFSET_OFS  = 8'h04;
  localparam logic [ADR_W-1:0] STATUS_OFS  = 8'h08;
  localparam logic [ADR_W-1:0] LEVEL_OFS   = 8'h0c;
  localparam logic [ADR_W-1:0] CH_BASE_OFS = 8'h10;
  localparam logic [ADR_W-1:0] CH_END_OFS  = 8'h30;
  localparam int               CH_SHIFT    = 3;
  localparam int               THR_SEL_BIT = 2;

  // Field positions
  localparam int STAT_ERR_BIT  = 8;
  localparam int STAT_MENU_LSB = 9;
  localparam int CFG_DRV_LSB   = 2;
  localparam int THR_LOW_LSB   = 16;

  // Values after reset
  localparam logic [LEVEL_W-1:0] OFFSET_RESET = 16'h0000;
  localparam logic [LEVEL_W-1:0] UPPER_RESET  = 16'h01f4;
  localparam logic [LEVEL_W-1:0] LOWER_RESET  = 16'h01c2;

  // Menu items and buttons
  localparam logic [ITEM_W-1:0] ITEM_UNIT   = 5'h10;
  localparam logic [ITEM_W-1:0] ITEM_OFFSET = 5'h11;
  localparam int BTN_SET  = 0;
  localparam int BTN_ESC  = 1;
  localparam int BTN_UP   = 2;
  localparam int BTN_DOWN = 3;

  typedef enum logic [1:0] {
    hysteresis_normally_open,
    hysteresis_normally_closed,
    window_normally_open,
    window_normally_closed
  } function_type;

  typedef enum logic [1:0] {
    high_side_drive,
    low_side_drive,
    push_pull_drive
  } drive_type;

  typedef enum logic [1:0] {MENU_CLOSED, MENU_SELECT, MENU_EDIT} menu_state_type;

  typedef struct packed {
    function_type         channel_function_setting;
    drive_type            channel_drive_type;
    logic [LEVEL_W-1:0]   upper_level;  // switch point or window upper
    logic [LEVEL_W-1:0]   lower_level;  // reset point or window lower
  } channel_cfg_type;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } wb_req_type;
endpackage : level_switch_pkg
`default_nettype wire

/* File: src/button_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module button_sync
  import level_switch_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 ce,
  input  wire logic [BTN_COUNT-1:0] button_pin,
  output logic      [BTN_COUNT-1:0] held,
  output logic      [BTN_COUNT-1:0] pressed
);
  typedef struct packed {
    logic [BTN_COUNT-1:0] meta;
    logic [BTN_COUNT-1:0] sync;
    logic [BTN_COUNT-1:0] prev;
  } sync_state_type;

  sync_state_type state_reg;
  sync_state_type state_next;

  // Two stages before use; first stage feeds the second only
  always_comb begin
    state_next = state_reg;
    if (ce) begin
      state_next.meta = button_pin;
      state_next.sync = state_reg.meta;
      state_next.prev = state_reg.sync;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Press is the rising edge of the settled level
  assign held    = state_reg.sync;
  assign pressed = state_reg.sync & ~state_reg.prev;
endmodule : button_sync
`default_nettype wire

/* File: src/channel_eval.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_eval
  import level_switch_pkg::*;
(
  input  wire channel_cfg_type     cfg,
  input  wire logic [LEVEL_W-1:0]  level,
  input  wire logic                hyst_state,
  output logic                     hyst_next,
  output logic                     active
);
  logic in_band;

  // Thresholds are millimetre levels on the referenced scale
  always_comb begin
    hyst_next = hyst_state;
    if (level >= cfg.upper_level) begin
      hyst_next = 1'b1;
    end else if (level <= cfg.lower_level) begin
      hyst_next = 1'b0;
    end
    in_band = (level <= cfg.upper_level) && (level >= cfg.lower_level);
    case (cfg.channel_function_setting)
      hysteresis_normally_open: begin
        active = hyst_next;
      end
      hysteresis_normally_closed: begin
        active = ~hyst_next;
      end
      window_normally_open: begin
        active = in_band;
      end
      default: begin
        active = ~in_band;
      end
    endcase
  end
endmodule : channel_eval
`default_nettype wire

/* File: src/level_switch_output_logic.sv */
// Functional notes
// - Menu opens only after confirm button held three seconds continuously.
// - Arrow buttons move between items and step the edited value.
// - Confirm inside the menu stores the value or accepts the selection.
// - Escape goes back exactly one menu level per press.
// - With millimetres selected, bar graph shows every output state.
// - With inches selected, the bar graph is blanked.
// - Lengths are referenced to probe end plus configured offset.
// - Two or four channels, each with its own settings.
// - Hysteresis: output switches when rising level reaches switch point.
// - Hysteresis: switches back only when falling level reaches reset point.
// - Window: inside band output active if open, inactive if closed.
// - Error status forces every switching output inactive.
// - Function setting picks hysteresis open, hysteresis closed, window open.
// - Hysteresis thresholds are switch and reset points in millimetres.
// - Window thresholds are upper and lower levels in millimetres.
// - Drive type picks high-side, low-side or push-pull output.
// - Function setting also offers window normally closed, inverted window.
// - Configuration mode closes after five minutes without button activity.
`timescale 1ns/1ps
`default_nettype none
module level_switch_output_logic
  import level_switch_pkg::*;
#(
  parameter int                 CHANNEL_COUNT   = 4,
  parameter logic [HOLD_W-1:0]  SET_HOLD_CYCLES = HOLD_W'(SET_HOLD_COUNT),
  parameter logic [IDLE_W-1:0]  IDLE_CYCLES     = IDLE_W'(IDLE_COUNT)
)(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  input  wire wb_req_type              wb_req,
  output logic                         wb_ack,
  output logic      [31:0]             wb_rdat,
  input  wire logic [BTN_COUNT-1:0]    button_pin,
  input  wire logic [LEVEL_W-1:0]      level_in,
  input  wire logic                    level_error,
  output logic      [CHANNEL_MAX-1:0]  channel_source,
  output logic      [CHANNEL_MAX-1:0]  channel_sink,
  output logic      [CHANNEL_MAX-1:0]  bar_graph,
  output logic                         unit_is_inch,
  output logic      [LEVEL_W-1:0]      display_level,
  output logic                         menu_open,
  output logic      [ITEM_W-1:0]       menu_item,
  output logic      [LEVEL_W-1:0]      edit_value
);
  localparam logic [HOLD_W-1:0] HOLD_LAST = SET_HOLD_CYCLES - 1'b1;
  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_CYCLES - 1'b1;
  localparam logic [ITEM_W-1:0] CH_ITEM_LAST = ITEM_W'(4 * CHANNEL_COUNT - 1);

  typedef struct packed {
    channel_cfg_type [CHANNEL_MAX-1:0] cfg;
    logic                              inch;
    logic [LEVEL_W-1:0]                offset;
    logic [CHANNEL_MAX-1:0]            hyst;
    logic [CHANNEL_MAX-1:0]            src;
    logic [CHANNEL_MAX-1:0]            sink;
    logic [CHANNEL_MAX-1:0]            bar;
    logic [LEVEL_W-1:0]                disp;
    menu_state_type                    menu;
    logic [ITEM_W-1:0]                 item;
    logic [LEVEL_W-1:0]                edit;
    logic [HOLD_W-1:0]                 hold_cnt;
    logic [IDLE_W-1:0]                 idle_cnt;
    logic                              ack;
    logic [31:0]                       rdat;
    logic                              menu_on;
  } top_state_type;

  top_state_type s_reg;
  top_state_type s_next;

  logic [BTN_COUNT-1:0]   btn_held;
  logic [BTN_COUNT-1:0]   btn_press;
  logic [LEVEL_W-1:0]     ref_level;
  logic [CHANNEL_MAX-1:0] hyst_d;
  logic [CHANNEL_MAX-1:0] act;
  logic [CHANNEL_MAX-1:0] eff;
  logic [CHANNEL_MAX-1:0] src_d;
  logic [CHANNEL_MAX-1:0] sink_d;
  logic                   bus_req;
  logic                   bus_wr;
  logic [ADR_W-1:0]       ch_rel;
  logic [1:0]             ch_idx;
  logic                   ch_hit;
  logic [31:0]            rd_word;
  logic [LEVEL_W-1:0]     cur_field;

  // Byte-lane merge for bus writes
  function automatic logic [31:0] merge32(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : merge32

  // Highest value an item may take while editing
  function automatic logic [LEVEL_W-1:0] item_max(input logic [ITEM_W-1:0] it);
    logic [LEVEL_W-1:0] m;
    m = 16'hffff;
    if (it == ITEM_UNIT) begin
      m = 16'h0001;
    end else if (it != ITEM_OFFSET && it[1:0] == 2'h0) begin
      m = 16'h0003;
    end else if (it != ITEM_OFFSET && it[1:0] == 2'h1) begin
      m = 16'h0002;
    end
    return m;
  endfunction : item_max

  // Button front end
  button_sync u_buttons (
    .clk        (clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .button_pin (button_pin),
    .held       (btn_held),
    .pressed    (btn_press)
  );

  assign ref_level = LEVEL_W'(level_in + s_reg.offset);

  for (genvar c = 0; c < CHANNEL_MAX; c++) begin : g_chan
    channel_eval u_eval (
      .cfg        (s_reg.cfg[c]),
      .level      (ref_level),
      .hyst_state (s_reg.hyst[c]),
      .hyst_next  (hyst_d[c]),
      .active     (act[c])
    );
    assign eff[c] = act[c] && !level_error && (c < CHANNEL_COUNT);
    always_comb begin
      case (s_reg.cfg[c].channel_drive_type)
        high_side_drive: begin
          src_d[c]  = eff[c];
          sink_d[c] = 1'b0;
        end
        low_side_drive: begin
          src_d[c]  = 1'b0;
          sink_d[c] = eff[c];
        end
        push_pull_drive: begin
          src_d[c]  = eff[c];
          sink_d[c] = !eff[c] && (c < CHANNEL_COUNT);
        end
        default: begin
          src_d[c]  = 1'b0;
          sink_d[c] = 1'b0;
        end
      endcase
    end
  end

  // Bus decode; channels own two words each
  assign bus_req = wb_req.cyc && wb_req.stb && !s_reg.ack;
  assign bus_wr  = bus_req && wb_req.we;
  assign ch_rel  = ADR_W'(wb_req.adr - CH_BASE_OFS);
  assign ch_idx  = ch_rel[CH_SHIFT +: 2];
  assign ch_hit  = (wb_req.adr >= CH_BASE_OFS) && (wb_req.adr < CH_END_OFS)
                   && (int'(ch_idx) < CHANNEL_COUNT);

  // Read mux; unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ch_hit && !wb_req.adr[THR_SEL_BIT]) begin
      rd_word[1:0] = s_reg.cfg[ch_idx].channel_function_setting;
      rd_word[CFG_DRV_LSB +: 2] = s_reg.cfg[ch_idx].channel_drive_type;
    end else if (ch_hit) begin
      rd_word[LEVEL_W-1:0] = s_reg.cfg[ch_idx].upper_level;
      rd_word[THR_LOW_LSB +: LEVEL_W] = s_reg.cfg[ch_idx].lower_level;
    end else begin
      case (wb_req.adr)
        CTRL_OFS: begin
          rd_word[0] = s_reg.inch;
        end
        OFFSET_OFS: begin
          rd_word[LEVEL_W-1:0] = s_reg.offset;
        end
        STATUS_OFS: begin
          rd_word[CHANNEL_MAX-1:0] = s_reg.src | s_reg.sink;
          rd_word[CHANNEL_MAX +: CHANNEL_MAX] = s_reg.bar;
          rd_word[STAT_ERR_BIT] = level_error;
          rd_word[STAT_MENU_LSB +: 2] = s_reg.menu;
        end
        LEVEL_OFS: begin
          rd_word[LEVEL_W-1:0] = s_reg.disp;
        end
        default: begin
          rd_word = 32'h0000_0000;
        end
      endcase
    end
  end

  // Value of the item under the cursor
  always_comb begin
    if (s_reg.item == ITEM_UNIT) begin
      cur_field = {15'h0000, s_reg.inch};
    end else if (s_reg.item == ITEM_OFFSET) begin
      cur_field = s_reg.offset;
    end else begin
      case (s_reg.item[1:0])
        2'h0: cur_field = {14'h0000, s_reg.cfg[s_reg.item[3:2]].channel_function_setting};
        2'h1: cur_field = {14'h0000, s_reg.cfg[s_reg.item[3:2]].channel_drive_type};
        2'h2: cur_field = s_reg.cfg[s_reg.item[3:2]].upper_level;
        default: cur_field = s_reg.cfg[s_reg.item[3:2]].lower_level;
      endcase
    end
  end

  // Next-state logic; ce low freezes everything
  always_comb begin
    s_next = s_reg;
    if (ce) begin
      // Outputs and hysteresis memory
      // hold between points
      s_next.hyst = hyst_d;
      s_next.src  = src_d;
      s_next.sink = sink_d;
      // bar shows outputs, blank in inches
      s_next.bar  = s_reg.inch ? '0 : eff;
      s_next.disp = ref_level;

      case (s_reg.menu)
        MENU_CLOSED: begin
          s_next.idle_cnt = '0;
          if (!btn_held[BTN_SET]) begin
            s_next.hold_cnt = '0;
          end else if (s_reg.hold_cnt == HOLD_LAST) begin
            s_next.hold_cnt = '0;
            s_next.menu     = MENU_SELECT;
            s_next.item     = '0;
          end else begin
            s_next.hold_cnt = s_reg.hold_cnt + 1'b1;
          end
        end
        MENU_SELECT: begin
          if (btn_press[BTN_UP]) begin
            if (s_reg.item == ITEM_OFFSET) begin
              s_next.item = '0;
            end else if (s_reg.item == CH_ITEM_LAST) begin
              s_next.item = ITEM_UNIT;
            end else begin
              s_next.item = s_reg.item + 1'b1;
            end
          end else if (btn_press[BTN_DOWN]) begin
            if (s_reg.item == '0) begin
              s_next.item = ITEM_OFFSET;
            end else if (s_reg.item == ITEM_UNIT) begin
              s_next.item = CH_ITEM_LAST;
            end else begin
              s_next.item = s_reg.item - 1'b1;
            end
          end else if (btn_press[BTN_SET]) begin
            s_next.menu = MENU_EDIT;
            s_next.edit = cur_field;
          end else if (btn_press[BTN_ESC]) begin
            s_next.menu = MENU_CLOSED;
          end
        end
        MENU_EDIT: begin
          if (btn_press[BTN_UP]) begin
            s_next.edit = (s_reg.edit >= item_max(s_reg.item)) ? '0 : s_reg.edit + 1'b1;
          end else if (btn_press[BTN_DOWN]) begin
            s_next.edit = (s_reg.edit == '0) ? item_max(s_reg.item) : s_reg.edit - 1'b1;
          end else if (btn_press[BTN_SET]) begin
            s_next.menu = MENU_SELECT;
            if (s_reg.item == ITEM_UNIT) begin
              s_next.inch = s_reg.edit[0];
            end else if (s_reg.item == ITEM_OFFSET) begin
              s_next.offset = s_reg.edit;
            end else begin
              case (s_reg.item[1:0])
                2'h0: s_next.cfg[s_reg.item[3:2]].channel_function_setting =
                        function_type'(s_reg.edit[1:0]);
                2'h1: s_next.cfg[s_reg.item[3:2]].channel_drive_type =
                        drive_type'(s_reg.edit[1:0]);
                // switch point or window upper in mm
                2'h2: s_next.cfg[s_reg.item[3:2]].upper_level = s_reg.edit;
                default: s_next.cfg[s_reg.item[3:2]].lower_level = s_reg.edit;
              endcase
            end
          end else if (btn_press[BTN_ESC]) begin
            s_next.menu = MENU_SELECT;
          end
        end
        default: begin
          s_next.menu = MENU_CLOSED;
        end
      endcase

      if (s_reg.menu != MENU_CLOSED) begin
        if (btn_press != '0) begin
          s_next.idle_cnt = '0;
        end else if (s_reg.idle_cnt == IDLE_LAST) begin
          s_next.idle_cnt = '0;
          s_next.menu     = MENU_CLOSED;
        end else begin
          s_next.idle_cnt = s_reg.idle_cnt + 1'b1;
        end
      end

      // Bus slave; a bus write overrides a menu store in the same cycle
      s_next.ack  = bus_req;
      s_next.rdat = bus_req ? rd_word : 32'h0000_0000;
      if (bus_wr && ch_hit && !wb_req.adr[THR_SEL_BIT] && wb_req.sel[0]) begin
        s_next.cfg[ch_idx].channel_function_setting = function_type'(wb_req.dat[1:0]);
        s_next.cfg[ch_idx].channel_drive_type = drive_type'(wb_req.dat[CFG_DRV_LSB +: 2]);
      end else if (bus_wr && ch_hit) begin
        {s_next.cfg[ch_idx].lower_level, s_next.cfg[ch_idx].upper_level} =
          merge32({s_reg.cfg[ch_idx].lower_level, s_reg.cfg[ch_idx].upper_level},
                  wb_req.dat, wb_req.sel);
      end else if (bus_wr && wb_req.adr == CTRL_OFS && wb_req.sel[0]) begin
        s_next.inch = wb_req.dat[0];
      end else if (bus_wr && wb_req.adr == OFFSET_OFS) begin
        s_next.offset = LEVEL_W'(merge32({16'h0000, s_reg.offset}, wb_req.dat, wb_req.sel));
      end
    end
    // Decoded ahead of the flop so the pin cannot glitch
    s_next.menu_on = (s_next.menu != MENU_CLOSED);
  end

  // State register with reset defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      for (int c = 0; c < CHANNEL_MAX; c++) begin
        s_reg.cfg[c].upper_level <= UPPER_RESET;
        s_reg.cfg[c].lower_level <= LOWER_RESET;
      end
      s_reg.offset <= OFFSET_RESET;
      s_reg.menu   <= MENU_CLOSED;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign wb_ack         = s_reg.ack;
  assign wb_rdat        = s_reg.rdat;
  assign channel_source = s_reg.src;
  assign channel_sink   = s_reg.sink;
  assign bar_graph      = s_reg.bar;
  assign unit_is_inch   = s_reg.inch;
  assign display_level  = s_reg.disp;
  assign menu_open      = s_reg.menu_on;
  assign menu_item      = s_reg.item;
  assign edit_value     = s_reg.edit;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_esc_edit;
    ce && s_reg.menu == MENU_EDIT && btn_press[BTN_ESC] && btn_press[BTN_SET:BTN_SET] == 1'b0
      && btn_press[BTN_UP] == 1'b0 && btn_press[BTN_DOWN] == 1'b0;
  endsequence
  sequence s_store_edit;
    ce && s_reg.menu == MENU_EDIT && btn_press == 4'h1 && !bus_wr;
  endsequence

  property p_open_after_hold;
    $rose(menu_open) |-> $past(s_reg.hold_cnt) == HOLD_LAST && $past(btn_held[BTN_SET]);
  endproperty
  a_open_after_hold: assert property (p_open_after_hold) else $error("menu opened early");

  property p_item_step;
    (ce && s_reg.menu == MENU_SELECT && btn_press == 4'h4 && s_reg.item < CH_ITEM_LAST)
      |=> menu_item == $past(s_reg.item) + 1'b1;
  endproperty
  a_item_step: assert property (p_item_step) else $error("item did not advance");

  property p_store;
    s_store_edit |=> cur_field == $past(s_reg.edit) && s_reg.menu == MENU_SELECT;
  endproperty
  a_store: assert property (p_store) else $error("edited value not stored");

  property p_esc_level;
    s_esc_edit |=> s_reg.menu == MENU_SELECT ##1 menu_open;
  endproperty
  a_esc_level: assert property (p_esc_level) else $error("escape skipped a level");

  property p_bar_mm;
    (ce && !s_reg.inch) |=> bar_graph == $past(eff);
  endproperty
  a_bar_mm: assert property (p_bar_mm) else $error("bar graph wrong in mm");

  property p_bar_inch;
    (ce && s_reg.inch) |=> bar_graph == '0;
  endproperty
  a_bar_inch: assert property (p_bar_inch) else $error("bar graph shown in inches");

  property p_reference;
    ce |=> display_level == LEVEL_W'($past(level_in) + $past(s_reg.offset));
  endproperty
  a_reference: assert property (p_reference) else $error("level not referenced");

  property p_rise_switch;
    (ce && ref_level >= s_reg.cfg[0].upper_level) |=> s_reg.hyst[0];
  endproperty
  a_rise_switch: assert property (p_rise_switch) else $error("switch point missed");

  property p_hold_band;
    (ce && ref_level < s_reg.cfg[0].upper_level && ref_level > s_reg.cfg[0].lower_level)
      |=> s_reg.hyst[0] == $past(s_reg.hyst[0]);
  endproperty
  a_hold_band: assert property (p_hold_band) else $error("hysteresis did not hold");

  property p_error_safe;
    (ce && level_error) |=> channel_source == '0 && bar_graph == '0;
  endproperty
  a_error_safe: assert property (p_error_safe) else $error("output active in error");

  property p_idle_close;
    (ce && menu_open && s_reg.idle_cnt == IDLE_LAST && btn_press == '0) |=> !menu_open;
  endproperty
  a_idle_close: assert property (p_idle_close) else $error("menu not closed on idle");
endmodule : level_switch_output_logic
`default_nettype wire

/* File: testbench/output_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module output_reader
  import level_switch_pkg::*;
(
  input  wire logic [CHANNEL_MAX-1:0] source,
  input  wire logic [CHANNEL_MAX-1:0] sink,
  output logic      [CHANNEL_MAX-1:0] seen
);
  // pulled-down controller input
  // An undriven pin reads low, so a released output never looks active
  assign seen = source & ~sink;
endmodule : output_reader
`default_nettype wire

/* File: testbench/test_level_switch_output_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module test_level_switch_output_logic;
  import level_switch_pkg::*;
  logic        clk, rst_b, ack, err, inch, mopen;
  wb_req_type  req;
  logic [31:0] rdat, q;
  logic [3:0]  btn, src, snk, bar, seen;
  logic [15:0] lvl, disp, edv;
  logic [4:0]  item;
  int          mismatches, cmp_count;

  level_switch_output_logic #(.CHANNEL_COUNT(4), .SET_HOLD_CYCLES(30'd10),
    .IDLE_CYCLES(37'd50)) dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .wb_req(req),
    .wb_ack(ack), .wb_rdat(rdat), .button_pin(btn), .level_in(lvl),
    .level_error(err), .channel_source(src), .channel_sink(snk), .bar_graph(bar),
    .unit_is_inch(inch), .display_level(disp), .menu_open(mopen),
    .menu_item(item), .edit_value(edv));
  output_reader reader (.source(src), .sink(snk), .seen(seen));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // Single classic cycle; held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    req <= '0;
  endtask : bus

  task automatic set_lvl(input logic [15:0] v);
    @(posedge clk);
    lvl <= v;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : set_lvl

  // One press: pin high four cycles, then released and settled
  task automatic press(input logic [3:0] b);
    @(posedge clk);
    btn <= b;
    repeat (4) @(posedge clk);
    btn <= 4'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : press

  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    {rst_b, err, btn, lvl, req, mismatches, cmp_count} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h0, q);
    set_lvl(16'h01f4);
    chk("src", 4'hf, src);
    set_lvl(16'h01d0);
    chk("src", 4'hf, src);
    set_lvl(16'h01c2);
    chk("src", 4'h0, src);
    bus(1'b1, CH_BASE_OFS + 8'h08, 32'h0a);
    set_lvl(16'h01d0);
    chk("src", 4'h2, src);
    chk("snk", 4'h0, snk);
    chk("seen", 4'h2, seen);
    chk("bar", 4'h2, bar);
    bus(1'b1, CH_BASE_OFS + 8'h08, 32'h0b);
    set_lvl(16'h01d0);
    chk("src", 4'h0, src);
    chk("snk", 4'h2, snk);
    bus(1'b1, CH_BASE_OFS + 8'h08, 32'h0a);
    err <= 1'b1;
    set_lvl(16'h01d0);
    chk("src", 4'h0, src);
    chk("snk", 4'h2, snk);
    @(posedge clk);
    err <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h1);
    chk("inch", 1'b1, inch);
    set_lvl(16'h01d0);
    chk("bar", 4'h0, bar);
    bus(1'b1, OFFSET_OFS, 32'h10);
    set_lvl(16'h0100);
    chk("disp", 16'h0110, disp);
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, q);
    btn <= 4'h1;
    repeat (6) @(posedge clk);
    chk("menu", 1'b0, mopen);
    repeat (12) @(posedge clk);
    chk("menu", 1'b1, mopen);
    btn <= 4'h0;
    press(4'h4);
    press(4'h4);
    chk("item", 5'h02, item);
    press(4'h1);
    chk("edit", 16'h01f4, edv);
    press(4'h4);
    chk("edit", 16'h01f5, edv);
    press(4'h1);
    bus(1'b0, CH_BASE_OFS + 8'h04, 32'h0);
    chk("thr0", 32'h01c2_01f5, q);
    press(4'h1);
    press(4'h2);
    chk("menu", 1'b1, mopen);
    press(4'h2);
    chk("menu", 1'b0, mopen);
    conclude();
  end
endmodule : test_level_switch_output_logic
`default_nettype wire
